// [logic/ccfg_calmem.sv]
`include "ccfg_cfg.svh"
`default_nettype none
// ==========================================================
// Calibration area store, registered read data, erased to ones
module ccfg_calmem import ccfg_pkg::*; #(
    parameter int AW = `CCFG_CAL_AW,
    parameter int DW = 14
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Access port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem; // Word array
        logic [DW-1:0] rd;               // Read register
    } ccfg_mem_s;

    ccfg_mem_s st;
    ccfg_mem_s next_st;

    // One-time cells only clear bits on a write
    always_comb begin
        next_st = st;
        next_st.rd = st.mem[addr];
        if (we) begin
            next_st.mem[addr] = st.mem[addr] & wdata;
        end
    end

    // Storage register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rd;
endmodule // ccfg_calmem
`default_nettype wire

// [logic/ccfg_cfg.svh]
`ifndef CCFG_CFG_SVH
`define CCFG_CFG_SVH

// ==========================================================
// Programming space map
`define CCFG_CFG_ADDR 14'h2007
`define CCFG_TEST_LO 14'h2000
`define CCFG_TEST_HI 14'h3fff
`define CCFG_PM_TOP 14'h0fff
`define CCFG_CAL_BASE 14'h2010
`define CCFG_CAL_AW 4
`define CCFG_CAL_FREQ_IDX 4'h0

// ==========================================================
// Configuration word fields
`define CCFG_CW_ERASED 14'h3fff
`define CCFG_CW_CPC 7
`define CCFG_CW_PROGRAM_PROTECT_HI 5
`define CCFG_CW_PROGRAM_PROTECT_LO 4
`define CCFG_CW_POWERUP_TIMER_ENABLE_N 3
`define CCFG_CW_WATCHDOG_ENABLE 2
`define CCFG_CW_CLOCK_SOURCE_SELECT 0

// ==========================================================
// Register indices (byte address is four times the index)
`define CCFG_IDX_AUX 12'h09e
`define CCFG_IDX_PADDR 12'h0a0
`define CCFG_IDX_PDATA 12'h0a1
`define CCFG_IDX_PCTRL 12'h0a2
`define CCFG_IDX_PSTAT 12'h0a3
`define CCFG_AUX_RESET 7'h00
`define CCFG_PCTRL_RD 0
`define CCFG_PCTRL_WR 1
`define CCFG_PSTAT_REFUSED 2

// ==========================================================
// Clocking
`define CCFG_INT_OSC_HZ 4000000
`define CCFG_CLK_OUT_DIV 4

`endif

// [logic/ccfg_pkg.sv]
`default_nettype none
package ccfg_pkg;
    // ==========================================================
    // Auxiliary pin control, bits 7..1 (bit 0 is the live pin)
    typedef struct packed {
        logic hold;     // Serial clock stretch enable
        logic gnd_d;    // Fourth port pair ground select
        logic gnd_c;    // Third port pair ground select
        logic pair;     // Serial pin pair select
        logic smbus;    // SMBus thresholds
        logic clkout;   // Clock-out enable
        logic pin_b;    // Pin B output latch
    } ccfg_aux_s;

    // Programming sequencer
    typedef enum logic [1:0] {PS_IDLE, PS_ISSUE, PS_CAPTURE} ccfg_pstate_e;
    typedef enum logic [1:0] {TG_PM, TG_CAL, TG_CFG, TG_NONE} ccfg_tgt_e;

    // Main block state
    typedef struct packed {
        ccfg_aux_s aux;
        logic [13:0] cfg_word;
        logic [13:0] prog_addr;
        logic [13:0] prog_data;
        logic refused;
        ccfg_pstate_e pst;
        ccfg_tgt_e tgt;
        logic op_wr;
        logic [31:0] prdata;
        logic [1:0] div;
        logic pin_b_out;
        logic pin_b_oe;
        logic pin_a_prev;
        logic btn_evt;
        logic pm_req;
        logic pm_we;
    } ccfg_state_s;
endpackage : ccfg_pkg
`default_nettype wire

// [logic/ccfg_sync.sv]
`include "ccfg_cfg.svh"
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser, change taken when stages 2 and 3 agree
module ccfg_sync import ccfg_pkg::*; #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pins and filtered result
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;   // Metastable stage, read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;    // Accepted level
    } ccfg_sync_s;

    ccfg_sync_s st;
    ccfg_sync_s next_st;

    // Shift and accept agreed bits
    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    // State register, pins assumed high (pull-up) at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule // ccfg_sync
`default_nettype wire

// [logic/ccfg_top.sv]
`include "ccfg_cfg.svh"
`default_nettype none
// ==========================================================
// Configuration word decode and auxiliary pin control
module ccfg_top import ccfg_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programming mode pin
    input wire logic prog_mode_pin,
    // Program memory access port
    output logic pm_req,
    output logic pm_we,
    output logic [11:0] pm_addr,
    output logic [13:0] pm_wdata,
    input wire logic [13:0] pm_rdata,
    // Oscillator pins
    input wire logic clock_pin_a_in,
    output logic clock_pin_a_pullup_en,
    output logic clock_pin_b_out,
    output logic clock_pin_b_oe,
    output logic crystal_amp_en,
    // CPU interrupt source
    input wire logic button_irq_enable,
    output logic button_event,
    // Decoded configuration
    output logic powerup_timer_en,
    output logic watchdog_en,
    output logic int_osc_sel,
    // Serial port controls
    input wire logic rx_buffer_full,
    output logic serial_clock_hold_low,
    output logic port_d_ground_select,
    output logic port_c_ground_select,
    output logic serial_pin_pair_select,
    output logic smbus_thresholds
);
    // ==========================================================
    // Helpers
    function automatic logic [11:0] reg_addr(input logic [11:0] idx);
        return {idx[9:0], 2'b00};
    endfunction

    function automatic ccfg_tgt_e region(input logic [13:0] a);
        if (a <= `CCFG_PM_TOP) begin
            return TG_PM;
        end else if (a[13:`CCFG_CAL_AW] == 10'(`CCFG_CAL_BASE >> `CCFG_CAL_AW)) begin
            return TG_CAL;
        end else if (a == `CCFG_CFG_ADDR) begin
            return TG_CFG;
        end else begin
            return TG_NONE;
        end
    endfunction

    ccfg_state_s st;
    ccfg_state_s next_st;
    logic [1:0] sync_q;      // Filtered prog mode and pin A
    logic prog_mode;         // Programming mode active
    logic pin_a;             // Filtered pin A level
    logic [13:0] cal_rdata;  // Calibration read data
    logic cal_we;            // Calibration write strobe
    logic in_int;            // Internal oscillator selected
    logic calib_protect_bit;               // Calibration writable
    logic pm_open;           // Program area accessible
    logic setup;             // APB setup phase
    logic access;            // APB completing access
    logic hit_aux;
    logic hit_paddr;
    logic hit_pdata;
    logic hit_pctrl;
    logic hit_pstat;
    logic mapped;
    logic [7:0] aux_rd;      // Auxiliary register read view

    // ==========================================================
    // Pin synchronisers and calibration store
    ccfg_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({prog_mode_pin, clock_pin_a_in}),
        .dout(sync_q)
    );
    assign prog_mode = sync_q[1];
    assign pin_a = sync_q[0];

    ccfg_calmem u_cal (
        .pclk(pclk),
        .presetn(presetn),
        .we(cal_we),
        .addr(st.prog_addr[`CCFG_CAL_AW-1:0]),
        .wdata(st.prog_data),
        .rdata(cal_rdata)
    );

    // ==========================================================
    // Configuration decode, zero means programmed
    assign calib_protect_bit = st.cfg_word[`CCFG_CW_CPC];
    assign pm_open = st.cfg_word[`CCFG_CW_PROGRAM_PROTECT_HI] & st.cfg_word[`CCFG_CW_PROGRAM_PROTECT_LO];
    assign powerup_timer_en = ~st.cfg_word[`CCFG_CW_POWERUP_TIMER_ENABLE_N];
    assign watchdog_en = st.cfg_word[`CCFG_CW_WATCHDOG_ENABLE];
    assign in_int = st.cfg_word[`CCFG_CW_CLOCK_SOURCE_SELECT];
    assign int_osc_sel = in_int;
    assign crystal_amp_en = ~in_int;
    assign clock_pin_a_pullup_en = in_int;

    // Serial port controls from the register, clock hold also gated by rx_buffer_full
    assign serial_clock_hold_low = st.aux.hold & rx_buffer_full;
    assign port_d_ground_select = st.aux.gnd_d;
    assign port_c_ground_select = st.aux.gnd_c;
    assign serial_pin_pair_select = st.aux.pair;
    assign smbus_thresholds = st.aux.smbus;

    // ==========================================================
    // APB decode, zero wait states
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_aux = paddr == reg_addr(`CCFG_IDX_AUX);
    assign hit_paddr = paddr == reg_addr(`CCFG_IDX_PADDR);
    assign hit_pdata = paddr == reg_addr(`CCFG_IDX_PDATA);
    assign hit_pctrl = paddr == reg_addr(`CCFG_IDX_PCTRL);
    assign hit_pstat = paddr == reg_addr(`CCFG_IDX_PSTAT);
    assign mapped = hit_aux | hit_paddr | hit_pdata | hit_pctrl | hit_pstat;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    // Pin A live only in internal mode, bit 0 not writable
    assign aux_rd = {st.aux, in_int & pin_a};
    // Calibration write only when unprotected
    assign cal_we = (st.pst == PS_ISSUE) && (st.tgt == TG_CAL) && st.op_wr && calib_protect_bit;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.pm_req = 1'b0;
        next_st.pm_we = 1'b0;
        // Read data captured in setup phase
        if (setup && !pwrite) begin
            unique case (1'b1)
                hit_aux: next_st.prdata = {24'h000000, aux_rd};
                hit_paddr: next_st.prdata = {18'h00000, st.prog_addr};
                hit_pdata: next_st.prdata = {18'h00000, st.prog_data};
                hit_pstat: next_st.prdata = {28'h0000000, in_int, st.refused, st.pst != PS_IDLE, prog_mode};
                default: next_st.prdata = 32'h00000000;
            endcase
        end
        // Register writes at the completing edge
        if (access && pwrite) begin
            if (hit_aux) begin
                next_st.aux = ccfg_aux_s'(pwdata[7:1]);
            end
            if (hit_paddr && st.pst == PS_IDLE) begin
                next_st.prog_addr = pwdata[13:0];
            end
            if (hit_pdata && st.pst == PS_IDLE) begin
                next_st.prog_data = pwdata[13:0];
            end
            if (hit_pstat && pwdata[`CCFG_PSTAT_REFUSED]) begin
                next_st.refused = 1'b0;
            end
        end
        // Programming sequencer
        unique case (st.pst)
            PS_IDLE: begin
                if (access && pwrite && hit_pctrl &&
                    (pwdata[`CCFG_PCTRL_RD] || pwdata[`CCFG_PCTRL_WR])) begin
                    next_st.op_wr = pwdata[`CCFG_PCTRL_WR];
                    next_st.tgt = region(st.prog_addr);
                    if (!prog_mode) begin
                        next_st.refused = 1'b1;
                    end else begin
                        unique case (region(st.prog_addr))
                            TG_PM: begin
                                if (pm_open) begin
                                    next_st.pm_req = 1'b1;
                                    next_st.pm_we = pwdata[`CCFG_PCTRL_WR];
                                    next_st.pst = PS_ISSUE;
                                end else begin
                                    next_st.refused = 1'b1;
                                end
                            end
                            TG_CAL: begin
                                next_st.pst = PS_ISSUE;
                                if (pwdata[`CCFG_PCTRL_WR] && !calib_protect_bit) begin
                                    next_st.refused = 1'b1;
                                end
                            end
                            TG_CFG: begin
                                if (pwdata[`CCFG_PCTRL_WR]) begin
                                    next_st.cfg_word = st.cfg_word & st.prog_data;
                                end else begin
                                    next_st.prog_data = st.cfg_word;
                                end
                            end
                            TG_NONE: begin
                                next_st.refused = 1'b1;
                            end
                        endcase
                    end
                end
            end
            PS_ISSUE: begin
                next_st.pst = PS_CAPTURE;
            end
            PS_CAPTURE: begin
                if (!st.op_wr) begin
                    next_st.prog_data = (st.tgt == TG_PM) ? pm_rdata : cal_rdata;
                end
                next_st.pst = PS_IDLE;
            end
            default: begin
                next_st.pst = PS_IDLE;
            end
        endcase
        // Clock divider and pin B drive
        next_st.div = st.div + 2'd1;
        next_st.pin_b_oe = in_int;
        if (!in_int) begin
            next_st.pin_b_out = 1'b0;
        end else if (st.aux.clkout) begin
            next_st.pin_b_out = st.div[1];
        end else begin
            next_st.pin_b_out = st.aux.pin_b;
        end
        // Falling edge of pin A as button event
        next_st.pin_a_prev = pin_a;
        next_st.btn_evt = in_int & button_irq_enable & st.pin_a_prev & ~pin_a;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg_word <= `CCFG_CW_ERASED;
            st.aux <= `CCFG_AUX_RESET;
            st.pin_a_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pm_req = st.pm_req;
    assign pm_we = st.pm_we;
    assign pm_addr = st.prog_addr[11:0];
    assign pm_wdata = st.prog_data;
    assign clock_pin_b_out = st.pin_b_out;
    assign clock_pin_b_oe = st.pin_b_oe;
    assign button_event = st.btn_evt;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cmd;  // Programming command accepted at this edge
    assign cmd = access && pwrite && hit_pctrl && st.pst == PS_IDLE && (pwdata[1] || pwdata[0]);

    property p_prog_gate;
        cmd && !prog_mode |=> st.refused && st.pst == PS_IDLE && !pm_req;
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("access outside programming mode");

    property p_cfg_only_clears;
        (st.cfg_word & ~$past(st.cfg_word)) == 14'h0000;
    endproperty
    a_cfg_only_clears: assert property (p_cfg_only_clears) else $error("config word gained bits");

    property p_cal_lock;
        !st.cfg_word[`CCFG_CW_CPC] |=> $stable(u_cal.st.mem);
    endproperty
    a_cal_lock: assert property (p_cal_lock) else $error("calibration written while protected");

    property p_pm_lock;
        cmd && prog_mode && region(st.prog_addr) == TG_PM && !pm_open |=> !pm_req ##1 !pm_req;
    endproperty
    a_pm_lock: assert property (p_pm_lock) else $error("protected program access issued");

    property p_pwrt;
        $fell(st.cfg_word[`CCFG_CW_POWERUP_TIMER_ENABLE_N]) |-> powerup_timer_en;
    endproperty
    a_pwrt: assert property (p_pwrt) else $error("power-up timer not enabled");

    property p_wdt;
        $fell(st.cfg_word[`CCFG_CW_WATCHDOG_ENABLE]) |-> !watchdog_en;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog still enabled");

    property p_osc_sel;
        $changed(int_osc_sel) |=> clock_pin_b_oe == int_osc_sel && crystal_amp_en != int_osc_sel;
    endproperty
    a_osc_sel: assert property (p_osc_sel) else $error("pin B drive wrong for oscillator mode");

    property p_pin_a_hs;
        setup && !pwrite && hit_aux && !in_int |=> prdata[0] == 1'b0;
    endproperty
    a_pin_a_hs: assert property (p_pin_a_hs) else $error("pin A read in crystal mode");

    property p_pin_b_latch;
        access && pwrite && hit_aux && !pwdata[2] && in_int ##1 in_int |=> clock_pin_b_out == $past(pwdata[1], 2);
    endproperty
    a_pin_b_latch: assert property (p_pin_b_latch) else $error("pin B does not follow latch");

    property p_clk_out;
        (in_int && st.aux.clkout) [*4] |-> clock_pin_b_out != $past(clock_pin_b_out, 2);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("pin B not toggling at divide by four");

    property p_hold;
        rx_buffer_full && st.aux.hold |-> serial_clock_hold_low;
    endproperty
    a_hold: assert property (p_hold) else $error("serial clock not held");

    c_refused: cover property (cmd && !prog_mode ##1 st.refused);
    c_pm_read: cover property (st.pst == PS_CAPTURE && st.tgt == TG_PM && !st.op_wr);
    c_clk_out: cover property ((in_int && st.aux.clkout) [*8]);
    c_button: cover property (button_event);
endmodule // ccfg_top
`default_nettype wire

// [sim/ccfg_osc_model.sv]
`default_nettype none
// ==========================================================
// Far side of the oscillator pins: button or external clock
module ccfg_osc_model (
    // Mode seen from the device
    input wire logic crystal_amp_en,
    input wire logic pullup_en,
    // Button press from the bench
    input wire logic press,
    // Level at pin A
    output logic pin_a
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ext_clk = 1'b0; // Free running source, unrelated to pclk
    initial forever #33 ext_clk = ~ext_clk;
    // Pin A level from whoever drives it
    always_comb begin
        if (crystal_amp_en)
            pin_a = ext_clk;
        else if (press)
            pin_a = 1'b0;
        else if (pullup_en)
            pin_a = 1'b1;
        else
            pin_a = ext_clk; // Nothing holds the line: no steady level
    end
endmodule // ccfg_osc_model
`default_nettype wire

// [sim/test_config_word_and_osc_pin_control.sv]
`default_nettype none
// ==========================================================
// Bench: register access, pin control and programming commands
module test_config_word_and_osc_pin_control import ccfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Register byte addresses
    localparam logic [11:0] A_AUX = 12'h278, A_PA = 12'h280, A_PD = 12'h284, A_PC = 12'h288, A_PS = 12'h28c;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_mode_pin, pm_req, pm_we, press, err, pb;
    logic [11:0] paddr, pm_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] pm_wdata, pm_rdata;
    logic [26:0] pm_seen; // Last program memory request: write flag, address, data
    logic clock_pin_a_in, clock_pin_a_pullup_en, clock_pin_b_out, clock_pin_b_oe, crystal_amp_en;
    logic button_irq_enable, button_event, powerup_timer_en, watchdog_en, int_osc_sel, rx_buffer_full;
    logic serial_clock_hold_low, port_d_ground_select, port_c_ground_select, serial_pin_pair_select, smbus_thresholds;
    int bad_count = 0, total_checks = 0, ev = 0, tg = 0;
    ccfg_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .prog_mode_pin, .pm_req, .pm_we, .pm_addr, .pm_wdata, .pm_rdata, .clock_pin_a_in, .clock_pin_a_pullup_en,
        .clock_pin_b_out, .clock_pin_b_oe, .crystal_amp_en, .button_irq_enable, .button_event, .powerup_timer_en,
        .watchdog_en, .int_osc_sel, .rx_buffer_full, .serial_clock_hold_low, .port_d_ground_select,
        .port_c_ground_select, .serial_pin_pair_select, .smbus_thresholds);
    ccfg_osc_model osc_u (.crystal_amp_en, .pullup_en(clock_pin_a_pullup_en), .press, .pin_a(clock_pin_a_in));
    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Program memory answers the cycle after a request
    always @(posedge pclk) if (pm_req) begin
        pm_rdata <= {2'b10, pm_addr};
        pm_seen <= {pm_we, pm_addr, pm_wdata};
    end
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; read data and error kept in rd and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait cycles, counting button pulses and pin B toggles
    task automatic cyc(input int c);
        repeat (c) begin
            @(negedge pclk);
            ev += (button_event === 1'b1);
            tg += (clock_pin_b_out !== pb);
            pb = clock_pin_b_out;
        end
    endtask
    // Programming command, then poll until idle; last status in rd
    task automatic cmd(input logic [13:0] a, input logic [13:0] d, input logic [1:0] c);
        apb(1'b1, A_PA, {18'h0, a});
        apb(1'b1, A_PD, {18'h0, d});
        apb(1'b1, A_PC, {30'h0, c});
        do begin
            apb(1'b0, A_PS, 32'h0);
        end while (rd[1] !== 1'b0);
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        test_done;
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, prog_mode_pin, press, button_irq_enable, rx_buffer_full} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pm_rdata = 14'h0000;
        pb = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cyc(6);
        apb(1'b0, A_AUX, 32'h0);
        chk("aux", 32'h1, rd);
        chk("decode", 32'h5, {29'h0, watchdog_en, powerup_timer_en, int_osc_sel});
        $display("test reset finished");
        // All aux bits, then pin A pressed with its event masked
        apb(1'b1, A_AUX, 32'hff);
        apb(1'b0, A_AUX, 32'h0);
        chk("aux", 32'hff, rd);
        chk("serial", 32'hf, {port_d_ground_select, port_c_ground_select, serial_pin_pair_select, smbus_thresholds});
        press <= 1'b1;
        ev = 0;
        cyc(10);
        apb(1'b0, A_AUX, 32'h0);
        chk("aux", 32'hfe, rd);
        chk("masked event", 32'h0, ev);
        cyc(1);
        tg = 0;
        cyc(40);
        chk("clock out toggles", 32'd20, tg);
        @(posedge pclk);
        press <= 1'b0;
        cyc(10);
        @(posedge pclk);
        press <= 1'b1;
        button_irq_enable <= 1'b1;
        ev = 0;
        cyc(12);
        chk("event", 32'h1, ev);
        $display("test aux finished");
        // Pin B as plain output
        apb(1'b1, A_AUX, 32'h02);
        cyc(3);
        chk("pin b", 32'h3, {30'h0, clock_pin_b_oe, clock_pin_b_out});
        apb(1'b1, A_AUX, 32'h80);
        rx_buffer_full <= 1'b1;
        cyc(3);
        tg = 0;
        cyc(8);
        chk("pin b toggles", 32'h0, tg + clock_pin_b_out);
        chk("hold", 32'h1, serial_clock_hold_low);
        @(posedge pclk);
        rx_buffer_full <= 1'b0;
        cyc(1);
        chk("hold", 32'h0, serial_clock_hold_low);
        apb(1'b0, 12'h3fc, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        $display("test pins finished");
        // Programming refused outside programming mode, then commands inside it
        cmd(14'h2007, 14'h3f62, 2'b10);
        chk("status", 32'h0c, rd);
        chk("decode", 32'h5, {29'h0, watchdog_en, powerup_timer_en, int_osc_sel});
        apb(1'b1, A_PS, 32'h4);
        @(posedge pclk);
        prog_mode_pin <= 1'b1;
        cyc(6);
        cmd(14'h0123, 14'h1555, 2'b10);
        chk("pm write", 32'h448d555, {5'h0, pm_seen});
        cmd(14'h0123, 14'h0, 2'b01);
        apb(1'b0, A_PD, 32'h0);
        chk("program word", 32'h2123, rd);
        cmd(14'h2010, 14'h1234, 2'b10);
        cmd(14'h2010, 14'h0, 2'b01);
        apb(1'b0, A_PD, 32'h0);
        chk("cal word", 32'h1234, rd);
        cmd(14'h2007, 14'h3f62, 2'b10);
        chk("status", 32'h01, rd);
        chk("decode", 32'h14, {26'h0, watchdog_en, powerup_timer_en, int_osc_sel, crystal_amp_en,
            clock_pin_a_pullup_en, clock_pin_b_oe});
        apb(1'b0, A_AUX, 32'h0);
        chk("aux", 32'h80, rd);
        cmd(14'h2007, 14'h0, 2'b01);
        apb(1'b0, A_PD, 32'h0);
        chk("config word", 32'h3f62, rd);
        cmd(14'h2011, 14'h0, 2'b10);
        chk("status", 32'h05, rd);
        apb(1'b1, A_PS, 32'h4);
        cmd(14'h0005, 14'h0, 2'b01);
        chk("status", 32'h05, rd);
        $display("test programming finished");
        test_done;
    end
endmodule // test_config_word_and_osc_pin_control
`default_nettype wire
